// >>> inc/sqs_pkg.sv
// Package of constants and types for the step ten configuration register
package sqs_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  STEP_TEN_CFG_ADDR  = 8'h9A;
	localparam logic [15:0] STEP_TEN_CFG_RESET = 16'h000A;
	localparam logic [15:0] STEP_TEN_WRITE_MASK = 16'hE01F;
	localparam logic [15:0] UNMAPPED_READ      = 16'h0000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int ENABLE_BIT = 15;
	localparam int GAIN_HI    = 14;
	localparam int GAIN_LO    = 13;
	localparam int NEG_BIT    = 4;
	localparam int POS_HI     = 3;
	localparam int POS_LO     = 0;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
	localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
	localparam logic [3:0] POS_FIRST_INTERNAL = 4'h8;

	// Decoded gain as a one-hot of x1, x2, x4
	typedef enum logic [2:0] {
		SQS_GAIN_X1 = 3'h1,
		SQS_GAIN_X2 = 3'h2,
		SQS_GAIN_X4 = 3'h4
	} sqs_gain_type;

	// Negative input choice
	typedef enum logic [1:0] {
		SQS_NEG_GROUND = 2'h0,
		SQS_NEG_INPUT7 = 2'h1,
		SQS_NEG_AUTO   = 2'h2
	} sqs_neg_type;
endpackage

// >>> design/sqs_step_cfg.sv
// Step ten configuration register of the secondary converter sequencer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Step joins the sequence only while enable bit 15 is one.
// - Gain bits 14:13 decode 00 to x1, 01 to x2, 10 and 11 to x4.
// - Bit 4 picks negative input: zero ground, one external input seven.
// - Positive codes 0 to 7 pick external inputs zero to seven.
// - Positive codes 8 to 15 route internal sources with automatic negative.
// - Negative select bit is ignored when negative input is automatic.
// - Register sits at 9Ah and resets to 000Ah.
module sqs_step_cfg
	import sqs_pkg::*;
(
	input  wire logic        clock,        // System clock, 200 MHz
	input  wire logic        rst,          // Asynchronous reset, active high
	input  wire logic [7:0]  reg_addr,     // Register address
	input  wire logic [15:0] reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output var  logic [15:0] reg_rdata,    // Read data, cycle after strobe
	input  wire logic        step_start,   // Sequencer begins step ten
	output var  logic        step_ten_enable,          // Captured enable
	output var  logic [2:0]  step_ten_gain,            // Captured gain one-hot
	output var  logic [3:0]  step_ten_positive_input_select, // Captured code
	output var  logic        step_pos_external,        // Positive is external
	output var  logic [1:0]  step_ten_negative_route   // Captured negative
);

	// ****************************************************************
	// Decode functions
	// ****************************************************************
	function automatic logic [2:0] gain_decode(input logic [1:0] code);
		if (code == GAIN_CODE_X1) begin
			gain_decode = SQS_GAIN_X1;
		end else if (code == GAIN_CODE_X2) begin
			gain_decode = SQS_GAIN_X2;
		end else begin
			gain_decode = SQS_GAIN_X4;
		end
	endfunction

	function automatic logic is_internal(input logic [3:0] code);
		is_internal = (code >= POS_FIRST_INTERNAL);
	endfunction

	function automatic logic [1:0] neg_decode(input logic [3:0] pos,
		input logic neg);
		if (is_internal(pos)) begin
			neg_decode = SQS_NEG_AUTO;
		end else if (neg) begin
			neg_decode = SQS_NEG_INPUT7;
		end else begin
			neg_decode = SQS_NEG_GROUND;
		end
	endfunction

	// ****************************************************************
	// Configuration storage
	// ****************************************************************
	logic [15:0] cfg_r;
	logic        hit;

	assign hit = (reg_addr == STEP_TEN_CFG_ADDR);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r <= STEP_TEN_CFG_RESET;
		end else if (reg_wr && hit) begin
			cfg_r <= reg_wdata & STEP_TEN_WRITE_MASK;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= UNMAPPED_READ;
		end else if (reg_rd && hit) begin
			reg_rdata <= cfg_r & STEP_TEN_WRITE_MASK;
		end else begin
			reg_rdata <= UNMAPPED_READ;
		end
	end

	// ****************************************************************
	// Capture at step start
	// ****************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_ten_enable <= 1'b0;
		end else if (step_start) begin
			step_ten_enable <= cfg_r[ENABLE_BIT];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_ten_gain <= SQS_GAIN_X1;
		end else if (step_start) begin
			step_ten_gain <= gain_decode(cfg_r[GAIN_HI:GAIN_LO]);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_ten_positive_input_select <= STEP_TEN_CFG_RESET[POS_HI:POS_LO];
		end else if (step_start) begin
			step_ten_positive_input_select <= cfg_r[POS_HI:POS_LO];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_pos_external <= 1'b0;
		end else if (step_start) begin
			step_pos_external <= !is_internal(cfg_r[POS_HI:POS_LO]);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_ten_negative_route <= SQS_NEG_AUTO;
		end else if (step_start) begin
			step_ten_negative_route <= neg_decode(cfg_r[POS_HI:POS_LO],
				cfg_r[NEG_BIT]);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence wr_hit_s;
		reg_wr && hit;
	endsequence

	sequence rd_hit_s;
		reg_rd && hit;
	endsequence

	reserved_zero_a: assert property (
		rd_hit_s |=> reg_rdata[12:5] == 8'h00)
		else $error("reserved bits read nonzero");
	write_readback_a: assert property (
		wr_hit_s ##1 rd_hit_s |=> reg_rdata == ($past(reg_wdata, 2)
			& STEP_TEN_WRITE_MASK))
		else $error("readback differs from masked write");
	miss_zero_a: assert property (
		reg_rd && !hit |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	enable_cap_a: assert property (
		step_start |=> step_ten_enable == $past(cfg_r[15]))
		else $error("enable not captured");
	gain_cap_a: assert property (
		step_start && cfg_r[14] |=> step_ten_gain == 3'h4)
		else $error("gain four not decoded");
	gain_two_a: assert property (
		step_start && cfg_r[14:13] == 2'h1 |=> step_ten_gain == 3'h2)
		else $error("gain two not decoded");
	neg_ext_a: assert property (
		step_start && !cfg_r[3] |=> step_ten_negative_route
			== {1'b0, $past(cfg_r[4])})
		else $error("negative select wrong");
	neg_auto_a: assert property (
		step_start && cfg_r[3] |=> step_ten_negative_route == 2'h2
			&& !step_pos_external)
		else $error("automatic negative not applied");
	hold_cap_a: assert property (
		!step_start |=> $stable(step_ten_gain) && $stable(step_ten_enable))
		else $error("captured settings moved without step start");
	pos_cap_a: assert property (
		step_start |=> step_ten_positive_input_select == $past(cfg_r[3:0]))
		else $error("positive select not captured");

	// ****************************************************************
	// Decode checks
	// ****************************************************************
	sequence ext_step_s;
		step_start && !cfg_r[POS_HI];
	endsequence

	sequence int_step_s;
		step_start && cfg_r[POS_HI];
	endsequence

	enable_set_a: assert property (
		step_start && cfg_r[15] |=> step_ten_enable)
		else $error("enable not set");
	enable_clear_a: assert property (
		step_start && !cfg_r[15] |=> !step_ten_enable)
		else $error("enable not cleared");
	gain_one_a: assert property (
		step_start && cfg_r[14:13] == 2'h0 |=> step_ten_gain == 3'h1)
		else $error("gain one not decoded");
	gain_four_lo_a: assert property (
		step_start && cfg_r[14:13] == 2'h2 |=> step_ten_gain == 3'h4)
		else $error("gain code two not decoded");
	gain_three_a: assert property (
		step_start && cfg_r[14:13] == 2'h3 |=> step_ten_gain == 3'h4)
		else $error("gain code three not decoded");
	gain_onehot_a: assert property (
		$onehot(step_ten_gain))
		else $error("gain not one-hot");
	ext_flag_a: assert property (
		ext_step_s |=> step_pos_external)
		else $error("external flag not set");
	ext_pos_a: assert property (
		ext_step_s |=> step_ten_positive_input_select < 4'h8)
		else $error("external code out of range");
	int_flag_a: assert property (
		int_step_s |=> !step_pos_external)
		else $error("internal code flagged external");
	int_pos_a: assert property (
		int_step_s |=> step_ten_positive_input_select >= 4'h8)
		else $error("internal code out of range");
	int_route_a: assert property (
		int_step_s |=> step_ten_negative_route == 2'h2)
		else $error("internal code without automatic negative");
	neg_ground_a: assert property (
		step_start && !cfg_r[3] && !cfg_r[4] |=> step_ten_negative_route == 2'h0)
		else $error("ground not selected");
	neg_seven_a: assert property (
		step_start && !cfg_r[3] && cfg_r[4] |=> step_ten_negative_route == 2'h1)
		else $error("input seven not selected");
	neg_ignore_a: assert property (
		step_start && cfg_r[3] && cfg_r[4] |=> step_ten_negative_route == 2'h2)
		else $error("negative bit not ignored");
	route_legal_a: assert property (
		step_ten_negative_route != 2'h3)
		else $error("illegal negative route");
	route_flag_a: assert property (
		step_pos_external == (step_ten_negative_route != 2'h2))
		else $error("route and external flag disagree");
	flag_code_a: assert property (
		step_pos_external == !step_ten_positive_input_select[3])
		else $error("external flag and code disagree");

	// ****************************************************************
	// Storage checks
	// ****************************************************************
	sequence wr_miss_s;
		reg_wr && !hit;
	endsequence

	cfg_reserved_a: assert property (
		cfg_r[12:5] == 8'h00)
		else $error("reserved bits stored");
	write_land_a: assert property (
		wr_hit_s |=> cfg_r == ($past(reg_wdata) & STEP_TEN_WRITE_MASK))
		else $error("write did not land");
	write_fields_a: assert property (
		wr_hit_s |=> cfg_r[15:13] == $past(reg_wdata[15:13]))
		else $error("upper fields not written");
	enable_store_a: assert property (
		wr_hit_s |=> cfg_r[15] == $past(reg_wdata[15]))
		else $error("enable bit not stored");
	neg_store_a: assert property (
		wr_hit_s |=> cfg_r[4] == $past(reg_wdata[4]))
		else $error("negative bit not stored");
	pos_store_a: assert property (
		wr_hit_s |=> cfg_r[3:0] == $past(reg_wdata[3:0]))
		else $error("positive code not stored");
	wr_miss_a: assert property (
		wr_miss_s |=> $stable(cfg_r))
		else $error("unmapped write changed register");
	no_write_a: assert property (
		!reg_wr |=> $stable(cfg_r))
		else $error("register moved without write");

	// ****************************************************************
	// Read and capture timing checks
	// ****************************************************************
	sequence step_wr_s;
		step_start && reg_wr && hit;
	endsequence

	idle_zero_a: assert property (
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without read strobe");
	read_value_a: assert property (
		rd_hit_s |=> reg_rdata == $past(cfg_r))
		else $error("read data differs from register");
	read_stand_a: assert property (
		rd_hit_s ##1 !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data stood too long");
	resv_after_wr_a: assert property (
		wr_hit_s ##1 rd_hit_s |=> reg_rdata[12:5] == 8'h00)
		else $error("reserved bits read after write");
	hold_sel_a: assert property (
		!step_start |=> $stable(step_ten_positive_input_select)
			&& $stable(step_pos_external) && $stable(step_ten_negative_route))
		else $error("selection moved without step start");
	old_value_a: assert property (
		step_wr_s |=> step_ten_positive_input_select == $past(cfg_r[3:0]))
		else $error("coinciding write captured");
	write_wait_a: assert property (
		wr_hit_s ##1 !step_start |=> $stable(step_ten_enable))
		else $error("write reached outputs early");

endmodule // sqs_step_cfg
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the step ten configuration register
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sqs_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        step_start = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [15:0] c;
	logic        en;
	logic [2:0]  gn;
	logic [3:0]  ps;
	logic        ext;
	logic [1:0]  ng;
	int          mismatches = 0;
	int          num_checks = 0;

	sqs_step_cfg sqs_step_cfg_inst (.clock(clock), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_start(step_start),
		.step_ten_enable(en), .step_ten_gain(gn),
		.step_ten_positive_input_select(ps), .step_pos_external(ext),
		.step_ten_negative_route(ng));

	initial begin
		forever #2.5 clock = ~clock;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] exp_out(input logic [15:0] v);
		logic [2:0] g;
		g = (v[14:13] == 2'h0) ? 3'h1 : (v[14:13] == 2'h1) ? 3'h2 : 3'h4;
		return {5'h00, v[15], g, v[3:0], ~v[3], v[3] ? 2'h2 : {1'b0, v[4]}};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic step(input logic wbit, input logic [15:0] d,
		input logic [15:0] exp);
		@(posedge clock);
		step_start <= 1'b1;
		reg_wr <= wbit;
		reg_wdata <= d;
		reg_addr <= STEP_TEN_CFG_ADDR;
		@(posedge clock);
		step_start <= 1'b0;
		reg_wr <= 1'b0;
		#1 chk({5'h00, en, gn, ps, ext, ng}, exp_out(exp));
	endtask

	task automatic final_report();
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		final_report();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		void'($urandom(75));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		#1 chk({5'h00, en, gn, ps, ext, ng}, exp_out(16'h000A));
		rd(8'h9A, 16'h000A);
		$display("Reset test done");
		for (int i = 0; i < 16; i++) begin
			c = {i[0], i[1:0], 8'hA5, i[1], i[3:0]};
			wr(8'h9A, c);
			rd(8'h9A, c & 16'hE01F);
			step(1'b0, c, c & 16'hE01F);
		end
		$display("Code table test done");
		for (int i = 0; i < 40; i++) begin
			c = 16'($urandom);
			wr(8'h9A, c);
			wr(8'($urandom_range(255, 155)), ~c);
			rd(8'h9A, c & 16'hE01F);
			rd(8'($urandom_range(153, 0)), 16'h0000);
			step(1'b1, ~c, c & 16'hE01F);
			step(1'b0, ~c, ~c & 16'hE01F);
		end
		$display("Random test done");
		final_report();
	end
endmodule // tb
`default_nettype wire
